/* hw/parallel_program_port.sv */
// Parallel programming port sequencer: entry, loads, erase and page writes.
`timescale 1ns/10ps
`default_nettype none
`include "parallel_program_port_cfg.svh"
module parallel_program_port (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Programming pins
  input  wire logic        strobeClockPin,
  input  wire logic        actionCodeBit0,
  input  wire logic        actionCodeBit1,
  input  wire logic        byteSelectFirst,
  input  wire logic        byteSelectSecond,
  input  wire logic        pageLatchPulse,
  input  wire logic        writeStrobe_n,
  input  wire logic        outputEnable_n,
  input  wire logic        resetPinLow,
  input  wire logic        highVoltDetect,
  input  wire logic [7:0]  dataIn,
  output var  logic [7:0]  dataOut,
  output var  logic        dataOe,
  output var  logic        readyBusyFlag,
  output var  logic        progMode,
  // Nonvolatile arrays
  output var  logic [12:0] arrAddr,
  output var  logic [15:0] arrWrData,
  output var  logic        arrFlashWr,
  output var  logic        arrEepromWr,
  output var  logic        arrEraseFlash,
  output var  logic        arrEraseEeprom,
  input  wire logic [15:0] arrRdData,
  input  wire logic [7:0]  arrEeRdData,
  // Fuses and lock bits
  input  wire logic [23:0] fuseStoreIn,
  output var  logic [23:0] fuseLatched,
  output var  logic        fuseWrEn,
  output var  logic [1:0]  fuseWrSel,
  output var  logic [7:0]  fuseWrData,
  output var  logic [7:0]  lockBits
);

  // ==================================================
  // Functions
  function automatic logic isWriteCmd(input logic [7:0] c);
    isWriteCmd = (c == `CMD_CHIP_ERASE) || (c == `CMD_WRITE_FUSE) ||
                 (c == `CMD_WRITE_LOCK) || (c == `CMD_WRITE_FLASH) ||
                 (c == `CMD_WRITE_EEPROM);
  endfunction

  // ==================================================
  // Pin synchronisers
  localparam int PW = 18;
  logic [PW-1:0] pinRaw;
  logic [PW-1:0] syncA_ff;
  logic [PW-1:0] syncB_ff;
  logic [PW-1:0] prev_ff;

  assign pinRaw = {dataIn, highVoltDetect, resetPinLow, outputEnable_n,
                   writeStrobe_n, pageLatchPulse, byteSelectSecond,
                   byteSelectFirst, actionCodeBit1, actionCodeBit0,
                   strobeClockPin};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      prev_ff  <= '0;
    end else begin
      syncA_ff <= pinRaw;
      syncB_ff <= syncA_ff;
      prev_ff  <= syncB_ff;
    end
  end

  logic       xtalRise;
  logic [1:0] action;
  logic       bs1;
  logic       bs2;
  logic       pageLatchRise;
  logic       wrFall;
  logic       oeLow;
  logic       rstLow;
  logic       hv;
  logic       hvRise;
  logic [7:0] dataSync;
  logic [3:0] entryPins;

  assign xtalRise      = syncB_ff[0] && !prev_ff[0];
  assign action        = syncB_ff[2:1];
  assign bs1           = syncB_ff[3];
  assign bs2           = syncB_ff[4];
  assign pageLatchRise = syncB_ff[5] && !prev_ff[5];
  assign wrFall        = !syncB_ff[6] && prev_ff[6];
  assign oeLow         = !syncB_ff[7];
  assign rstLow        = syncB_ff[8];
  assign hv            = syncB_ff[9];
  assign hvRise        = syncB_ff[9] && !prev_ff[9];
  assign dataSync      = syncB_ff[17:10];
  assign entryPins     = {syncB_ff[5], syncB_ff[2], syncB_ff[1], syncB_ff[3]};

  // ==================================================
  // Programming mode entry
  parallel_program_port_pkg::entry_state_type entSt_ff;
  logic [2:0] toggleCnt_ff;
  logic [3:0] guardCnt_ff;
  logic [3:0] entryHold_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      entSt_ff     <= parallel_program_port_pkg::ENT_OFF;
      toggleCnt_ff <= 3'h0;
      guardCnt_ff  <= 4'h0;
      entryHold_ff <= 4'h0;
    end else begin
      case (entSt_ff)
        parallel_program_port_pkg::ENT_OFF: begin
          if (!rstLow) begin
            toggleCnt_ff <= 3'h0;
          end else if (xtalRise && toggleCnt_ff != `MIN_TOGGLES) begin
            toggleCnt_ff <= toggleCnt_ff + 3'h1;
          end
          if (toggleCnt_ff == `MIN_TOGGLES && rstLow) begin
            entSt_ff <= parallel_program_port_pkg::ENT_ARM;
          end
        end
        parallel_program_port_pkg::ENT_ARM: begin
          if (hvRise && entryPins == 4'h0) begin
            entSt_ff     <= parallel_program_port_pkg::ENT_GUARD;
            entryHold_ff <= entryPins;
            guardCnt_ff  <= 4'h0;
          end else if (hvRise || !(rstLow || hv)) begin
            entSt_ff     <= parallel_program_port_pkg::ENT_OFF;
            toggleCnt_ff <= 3'h0;
          end
        end
        parallel_program_port_pkg::ENT_GUARD: begin
          if (entryPins != entryHold_ff || !hv) begin
            entSt_ff <= parallel_program_port_pkg::ENT_FAIL;
          end else if (guardCnt_ff == 4'(`ENTRY_GUARD_CYC - 1)) begin
            entSt_ff <= parallel_program_port_pkg::ENT_ON;
          end else begin
            guardCnt_ff <= guardCnt_ff + 4'h1;
          end
        end
        parallel_program_port_pkg::ENT_ON: begin
          if (!hv) begin
            entSt_ff     <= parallel_program_port_pkg::ENT_OFF;
            toggleCnt_ff <= 3'h0;
          end
        end
        parallel_program_port_pkg::ENT_FAIL: begin
          if (!hv) begin
            entSt_ff     <= parallel_program_port_pkg::ENT_OFF;
            toggleCnt_ff <= 3'h0;
          end
        end
        default: begin
          entSt_ff <= parallel_program_port_pkg::ENT_OFF;
        end
      endcase
    end
  end

  logic active;
  assign active = (entSt_ff == parallel_program_port_pkg::ENT_ON);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      progMode    <= 1'b0;
      fuseLatched <= `FUSE_RESET;
    end else begin
      progMode <= active;
      if (entSt_ff == parallel_program_port_pkg::ENT_GUARD &&
          guardCnt_ff == 4'(`ENTRY_GUARD_CYC - 1)) begin
        fuseLatched <= fuseStoreIn;
      end
    end
  end

  // ==================================================
  // Command, address and data loading
  logic [7:0] cmd_ff;
  logic [7:0] addrLo_ff;
  logic [7:0] addrHi_ff;
  logic [7:0] addrExt_ff;
  logic [7:0] dataLo_ff;
  logic [7:0] dataHi_ff;
  logic [7:0] dataExt_ff;
  logic       hiLoaded_ff;
  logic       busy;

  always_ff @(posedge clk) begin
    if (!rst_n || !active) begin
      cmd_ff      <= `CMD_NOP;
      addrLo_ff   <= 8'h00;
      addrHi_ff   <= 8'h00;
      addrExt_ff  <= 8'h00;
      dataLo_ff   <= 8'h00;
      dataHi_ff   <= 8'h00;
      dataExt_ff  <= 8'h00;
      hiLoaded_ff <= 1'b0;
    end else if (xtalRise) begin
      case (action)
        `ACT_LOAD_ADDR: begin
          if (bs1) begin
            addrHi_ff   <= dataSync;
            hiLoaded_ff <= 1'b1;
          end else if (bs2) begin
            addrExt_ff <= dataSync;
          end else begin
            addrLo_ff <= dataSync;
          end
        end
        `ACT_LOAD_DATA: begin
          if (bs1) begin
            dataHi_ff <= dataSync;
          end else if (bs2) begin
            dataExt_ff <= dataSync;
          end else begin
            dataLo_ff <= dataSync;
          end
        end
        `ACT_LOAD_CMD: begin
          cmd_ff      <= dataSync;
          hiLoaded_ff <= 1'b0;
        end
        default: begin
          cmd_ff <= cmd_ff;
        end
      endcase
    end
  end

  // ==================================================
  // Page buffer loading
  page_buffer_if pb ();
  logic        bufWr_ff;
  logic [5:0]  bufWrAddr_ff;
  logic [15:0] bufWrData_ff;
  logic [5:0]  bufRdAddr_ff;
  logic        isEeCmd;
  assign isEeCmd = (cmd_ff == `CMD_WRITE_EEPROM);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bufWr_ff     <= 1'b0;
      bufWrAddr_ff <= 6'h00;
      bufWrData_ff <= 16'h0000;
    end else begin
      bufWr_ff <= 1'b0;
      if (active && pageLatchRise && !busy) begin
        if (isEeCmd) begin
          bufWr_ff     <= 1'b1;
          bufWrAddr_ff <= {4'h0, addrLo_ff[1:0]};
          bufWrData_ff <= {8'h00, dataLo_ff};
        end else if (bs1 && cmd_ff == `CMD_WRITE_FLASH) begin
          bufWr_ff     <= 1'b1;
          bufWrAddr_ff <= addrLo_ff[5:0];
          bufWrData_ff <= {dataHi_ff, dataLo_ff};
        end
      end
    end
  end

  assign pb.wrEn   = bufWr_ff;
  assign pb.wrAddr = bufWrAddr_ff;
  assign pb.wrData = bufWrData_ff;
  assign pb.rdAddr = bufRdAddr_ff;

  page_buffer_mem u_buf (
    .clk      (clk),
    .buf_port (pb.mem)
  );

  // ==================================================
  // Operation sequencer
  parallel_program_port_pkg::op_state_type opSt_ff;
  logic [11:0] opCnt_ff;
  logic [6:0]  streamIdx_ff;
  logic        streamWr_ff;
  logic        streamEe_ff;
  logic [6:0]  pageLen;
  logic [12:0] pageBase;
  logic        keepEe;

  assign busy     = (opSt_ff != parallel_program_port_pkg::OP_IDLE);
  assign pageLen  = isEeCmd ? `EE_PAGE_BYTES : `FLASH_PAGE_WORDS;
  assign pageBase = isEeCmd ? {4'h0, addrHi_ff[0], addrLo_ff[7:2], 2'h0}
                            : {addrHi_ff[4:0], addrLo_ff[7:6], 6'h00};
  assign keepEe   = !fuseStoreIn[`FUSE_KEEP_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n || !active) begin
      opSt_ff        <= parallel_program_port_pkg::OP_IDLE;
      opCnt_ff       <= 12'h000;
      streamIdx_ff   <= 7'h00;
      streamWr_ff    <= 1'b0;
      streamEe_ff    <= 1'b0;
      bufRdAddr_ff   <= 6'h00;
      arrEraseFlash  <= 1'b0;
      arrEraseEeprom <= 1'b0;
      fuseWrEn       <= 1'b0;
      fuseWrSel      <= 2'h0;
      fuseWrData     <= 8'h00;
      lockBits       <= `LOCK_RESET;
    end else begin
      fuseWrEn    <= 1'b0;
      streamWr_ff <= 1'b0;
      case (opSt_ff)
        parallel_program_port_pkg::OP_IDLE: begin
          if (wrFall && isWriteCmd(cmd_ff)) begin
            case (cmd_ff)
              `CMD_CHIP_ERASE: begin
                opSt_ff        <= parallel_program_port_pkg::OP_ERASE;
                opCnt_ff       <= `ERASE_CYC;
                arrEraseFlash  <= 1'b1;
                arrEraseEeprom <= !keepEe;
              end
              `CMD_WRITE_FUSE: begin
                opSt_ff    <= parallel_program_port_pkg::OP_WAIT;
                opCnt_ff   <= `FUSE_CYC;
                fuseWrEn   <= 1'b1;
                fuseWrSel  <= {bs2, bs1};
                fuseWrData <= dataLo_ff;
              end
              `CMD_WRITE_LOCK: begin
                opSt_ff  <= parallel_program_port_pkg::OP_WAIT;
                opCnt_ff <= `FUSE_CYC;
                lockBits <= lockBits & dataLo_ff;
              end
              default: begin
                if (isEeCmd || hiLoaded_ff) begin
                  opSt_ff      <= parallel_program_port_pkg::OP_STREAM;
                  streamIdx_ff <= 7'h00;
                  bufRdAddr_ff <= 6'h00;
                  streamEe_ff  <= isEeCmd;
                end
              end
            endcase
          end
        end
        parallel_program_port_pkg::OP_STREAM: begin
          streamWr_ff  <= 1'b1;
          streamIdx_ff <= streamIdx_ff + 7'h1;
          bufRdAddr_ff <= 6'(streamIdx_ff + 7'h1);
          if (streamIdx_ff == pageLen - 7'h1) begin
            opSt_ff  <= parallel_program_port_pkg::OP_WAIT;
            opCnt_ff <= `PROG_CYC;
          end
        end
        parallel_program_port_pkg::OP_WAIT: begin
          if (opCnt_ff == 12'h000) begin
            opSt_ff <= parallel_program_port_pkg::OP_IDLE;
          end else begin
            opCnt_ff <= opCnt_ff - 12'h001;
          end
        end
        parallel_program_port_pkg::OP_ERASE: begin
          if (opCnt_ff == 12'h000) begin
            opSt_ff        <= parallel_program_port_pkg::OP_IDLE;
            arrEraseFlash  <= 1'b0;
            arrEraseEeprom <= 1'b0;
            lockBits       <= `LOCK_RESET;
          end else begin
            opCnt_ff <= opCnt_ff - 12'h001;
          end
        end
        default: begin
          opSt_ff <= parallel_program_port_pkg::OP_IDLE;
        end
      endcase
      if (xtalRise && action == `ACT_LOAD_CMD && dataSync == `CMD_NOP &&
          !busy) begin
        arrEraseFlash  <= 1'b0;
        arrEraseEeprom <= 1'b0;
      end
    end
  end

  // Write strobes seen while busy fall through the idle-only decode above.
  logic [6:0] streamPrev_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      streamPrev_ff <= 7'h00;
      readyBusyFlag <= 1'b1;
    end else begin
      streamPrev_ff <= streamIdx_ff;
      readyBusyFlag <= !busy;
    end
  end

  // ==================================================
  // Array address, writes and read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arrAddr     <= 13'h0000;
      arrWrData   <= 16'h0000;
      arrFlashWr  <= 1'b0;
      arrEepromWr <= 1'b0;
    end else begin
      arrFlashWr  <= streamWr_ff && !streamEe_ff;
      arrEepromWr <= streamWr_ff && streamEe_ff;
      arrWrData   <= pb.rdData;
      if (streamWr_ff) begin
        arrAddr <= pageBase | {6'h00, streamPrev_ff};
      end else if (cmd_ff == `CMD_READ_EEPROM) begin
        arrAddr <= {4'h0, addrHi_ff[0], addrLo_ff};
      end else begin
        arrAddr <= {addrHi_ff[4:0], addrLo_ff};
      end
    end
  end

  logic [7:0] readByte;

  always_comb begin
    readByte = 8'h00;
    case (cmd_ff)
      `CMD_READ_FLASH:    readByte = bs1 ? arrRdData[15:8] : arrRdData[7:0];
      `CMD_READ_EEPROM:   readByte = arrEeRdData;
      `CMD_READ_SIG: begin
        if (bs1) begin
          readByte = `CAL_BYTE;
        end else if (addrLo_ff == 8'h00) begin
          readByte = `SIG_BYTE0;
        end else if (addrLo_ff == 8'h01) begin
          readByte = `SIG_BYTE1;
        end else if (addrLo_ff == 8'h02) begin
          readByte = `SIG_BYTE2;
        end
      end
      `CMD_READ_FUSELOCK: begin
        case ({bs2, bs1})
          2'h0:    readByte = fuseStoreIn[7:0];
          2'h3:    readByte = fuseStoreIn[15:8];
          2'h2:    readByte = fuseStoreIn[23:16];
          default: readByte = lockBits;
        endcase
      end
      default: readByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataOe  <= 1'b0;
      dataOut <= 8'h00;
    end else begin
      dataOe  <= active && oeLow;
      dataOut <= readByte;
    end
  end

endmodule
`default_nettype wire

/* hw/parallel_program_port_cfg.svh */
// Constants of the parallel programming port: codes, sizes and timing counts.
`ifndef PARALLEL_PROGRAM_PORT_CFG_SVH
`define PARALLEL_PROGRAM_PORT_CFG_SVH

// ==================================================
// Action codes on the two action code pins, taken at the strobe clock rise
`define ACT_LOAD_ADDR     2'h0
`define ACT_LOAD_DATA     2'h1
`define ACT_LOAD_CMD      2'h2
`define ACT_IDLE          2'h3

// ==================================================
// Command bytes
`define CMD_NOP           8'h00
`define CMD_CHIP_ERASE    8'h80
`define CMD_WRITE_FUSE    8'h40
`define CMD_WRITE_LOCK    8'h20
`define CMD_WRITE_FLASH   8'h10
`define CMD_WRITE_EEPROM  8'h11
`define CMD_READ_SIG      8'h08
`define CMD_READ_FUSELOCK 8'h04
`define CMD_READ_FLASH    8'h02
`define CMD_READ_EEPROM   8'h03

// ==================================================
// Memory organisation
`define FLASH_PAGE_WORDS  7'h40
`define EE_PAGE_BYTES     7'h04
`define BUF_AW            6
`define ARR_AW            13
`define FUSE_KEEP_BIT     11

// ==================================================
// Reset values, signature and calibration bytes
`define LOCK_RESET        8'hff
`define FUSE_RESET        24'hffffff
`define SIG_BYTE0         8'h5a
`define SIG_BYTE1         8'ha5
`define SIG_BYTE2         8'h3c
`define CAL_BYTE          8'h80

// ==================================================
// Timing
`define CLK_PERIOD_NS     25
`define ENTRY_GUARD_NS    100
`define ENTRY_GUARD_CYC   ((`ENTRY_GUARD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_TOGGLES       3'h6
`define ERASE_CYC         12'h400
`define PROG_CYC          12'h200
`define FUSE_CYC          12'h020

`endif

/* hw/parallel_program_port_pkg.sv */
// Types of the parallel programming port.
package parallel_program_port_pkg;

  typedef enum logic [4:0] {
    ENT_OFF   = 5'h01,
    ENT_ARM   = 5'h02,
    ENT_GUARD = 5'h04,
    ENT_ON    = 5'h08,
    ENT_FAIL  = 5'h10
  } entry_state_type;

  typedef enum logic [3:0] {
    OP_IDLE   = 4'h1,
    OP_STREAM = 4'h2,
    OP_WAIT   = 4'h4,
    OP_ERASE  = 4'h8
  } op_state_type;

endpackage

/* hw/page_buffer_if.sv */
// Connection between the port sequencer and its page buffer memory.
`timescale 1ns/10ps
`default_nettype none
interface page_buffer_if;
  logic        wrEn;
  logic [5:0]  wrAddr;
  logic [15:0] wrData;
  logic [5:0]  rdAddr;
  logic [15:0] rdData;

  modport seq (output wrEn, output wrAddr, output wrData, output rdAddr,
               input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr,
               output rdData);
endinterface
`default_nettype wire

/* hw/page_buffer_mem.sv */
// Page buffer memory with a registered read port.
`timescale 1ns/10ps
`default_nettype none
module page_buffer_mem (
  // Clock
  input  wire logic  clk,
  // Buffer access
  page_buffer_if.mem buf_port
);

  logic [15:0] store [0:63];
  logic [15:0] rdData_ff;

  always_ff @(posedge clk) begin
    if (buf_port.wrEn) begin
      store[buf_port.wrAddr] <= buf_port.wrData;
    end
  end

  always_ff @(posedge clk) begin
    rdData_ff <= store[buf_port.rdAddr];
  end

  assign buf_port.rdData = rdData_ff;

endmodule
`default_nettype wire

/* hw/parallel_program_port_inc.sv */
// Includes the constants header for the port sources.
`include "parallel_program_port_cfg.svh"

/* tb/parallel_program_port_chk.sv */
// Concurrent checks on the pins of the parallel programming port.
`timescale 1ns/10ps
`default_nettype none
module parallel_program_port_chk (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Pins
  input  wire logic        outputEnable_n,
  input  wire logic        highVoltDetect,
  input  wire logic [23:0] fuseStoreIn,
  input  wire logic        dataOe,
  input  wire logic        readyBusyFlag,
  input  wire logic        progMode,
  // Arrays and fuses
  input  wire logic [12:0] arrAddr,
  input  wire logic        arrFlashWr,
  input  wire logic        arrEraseFlash,
  input  wire logic        arrEraseEeprom,
  input  wire logic [23:0] fuseLatched,
  input  wire logic [7:0]  lockBits
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_oe;
    outputEnable_n [*5] |-> !dataOe;
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven with oe high");

  property p_flash_busy;
    arrFlashWr |-> !readyBusyFlag && progMode;
  endproperty
  a_flash_busy: assert property (p_flash_busy)
    else $error("flash write while ready");

  property p_page_base;
    $rose(arrFlashWr) |-> arrAddr[5:0] == 6'h00;
  endproperty
  a_page_base: assert property (p_page_base)
    else $error("page stream not at page base");

  property p_addr_step;
    arrFlashWr && $past(arrFlashWr) |-> arrAddr == $past(arrAddr) + 13'h1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("page stream address skipped");

  property p_lock_end;
    $fell(arrEraseFlash) |-> ##[0:2] lockBits == 8'hff;
  endproperty
  a_lock_end: assert property (p_lock_end)
    else $error("lock bits not cleared after erase");

  property p_keep;
    $rose(arrEraseFlash) |-> arrEraseEeprom == fuseStoreIn[11];
  endproperty
  a_keep: assert property (p_keep)
    else $error("eeprom erase against keep fuse");

  property p_fuse_hold;
    progMode && $past(progMode) |-> $stable(fuseLatched);
  endproperty
  a_fuse_hold: assert property (p_fuse_hold)
    else $error("latched fuses changed in mode");

  property p_entry;
    $rose(progMode) |-> $past(highVoltDetect, 4);
  endproperty
  a_entry: assert property (p_entry)
    else $error("mode entered without guard time");
endmodule

bind parallel_program_port parallel_program_port_chk u_chk (
  .clk(clk), .rst_n(rst_n), .outputEnable_n(outputEnable_n),
  .highVoltDetect(highVoltDetect), .fuseStoreIn(fuseStoreIn),
  .dataOe(dataOe), .readyBusyFlag(readyBusyFlag), .progMode(progMode),
  .arrAddr(arrAddr), .arrFlashWr(arrFlashWr),
  .arrEraseFlash(arrEraseFlash), .arrEraseEeprom(arrEraseEeprom),
  .fuseLatched(fuseLatched), .lockBits(lockBits)
);
`default_nettype wire

/* tb/nv_array_model.sv */
// Behavioural flash and EEPROM arrays behind the port.
`timescale 1ns/10ps
`default_nettype none
module nv_array_model (
  // Clock
  input  wire logic        clk,
  // Array access
  input  wire logic [12:0] arrAddr,
  input  wire logic [15:0] arrWrData,
  input  wire logic        arrFlashWr,
  input  wire logic        arrEepromWr,
  input  wire logic        arrEraseFlash,
  input  wire logic        arrEraseEeprom,
  output var  logic [15:0] arrRdData,
  output var  logic [7:0]  arrEeRdData
);
  logic [15:0] flashMem [8192];
  logic [7:0]  eeMem [512];
  logic        eraseDly = 1'b0;

  initial begin
    for (int k = 0; k < 8192; k++) begin
      flashMem[k] = {k[7:0], ~k[7:0]};
    end
    for (int k = 0; k < 512; k++) begin
      eeMem[k] = k[7:0] ^ 8'h5c;
    end
  end

  // Erase is applied once, at the start of the erase level.
  always @(posedge clk) begin
    eraseDly <= arrEraseFlash;
    if (arrEraseFlash && !eraseDly) begin
      foreach (flashMem[k]) flashMem[k] <= 16'hffff;
      if (arrEraseEeprom) begin
        foreach (eeMem[k]) eeMem[k] <= 8'hff;
      end
    end
    if (arrFlashWr) begin
      flashMem[arrAddr] <= arrWrData;
    end
    if (arrEepromWr) begin
      eeMem[arrAddr[8:0]] <= arrWrData[7:0];
    end
  end

  assign arrRdData = flashMem[arrAddr];
  assign arrEeRdData = eeMem[arrAddr[8:0]];
endmodule
`default_nettype wire

/* tb/tb_parallel_program_port.sv */
// Self-checking bench of the parallel programming port.
`timescale 1ns/10ps
`default_nettype none
module tb_parallel_program_port;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        strobeClockPin = 1'b0;
  logic        actionCodeBit0 = 1'b1;
  logic        actionCodeBit1 = 1'b1;
  logic        byteSelectFirst = 1'b0;
  logic        byteSelectSecond = 1'b0;
  logic        pageLatchPulse = 1'b0;
  logic        writeStrobe_n = 1'b1;
  logic        outputEnable_n = 1'b1;
  logic        resetPinLow = 1'b0;
  logic        highVoltDetect = 1'b0;
  logic [7:0]  dataIn = 8'h00;
  logic [23:0] fuseStore = 24'hfd9962;
  logic [7:0]  dataOut;
  logic        dataOe, readyBusyFlag, progMode;
  logic [12:0] arrAddr;
  logic [15:0] arrWrData, arrRdData;
  logic [7:0]  arrEeRdData, lockBits;
  logic        arrFlashWr, arrEepromWr, arrEraseFlash, arrEraseEeprom;
  int          n_errors = 0;
  int          comparisons = 0;
  // Rows: command, address low, expected byte, {select 2, select 1}.
  logic [31:0] rows [11] = '{32'h08005a00, 32'h0801a500, 32'h08023c00,
    32'h08008001, 32'h04006200, 32'h04009903, 32'h0400fd02, 32'h0400ff01,
    32'h0205fa00, 32'h02050501, 32'h03075b00};

  initial begin
    forever #12.5 clk = ~clk;
  end

  parallel_program_port dut (
    .clk(clk), .rst_n(rst_n), .strobeClockPin(strobeClockPin),
    .actionCodeBit0(actionCodeBit0), .actionCodeBit1(actionCodeBit1),
    .byteSelectFirst(byteSelectFirst), .byteSelectSecond(byteSelectSecond),
    .pageLatchPulse(pageLatchPulse), .writeStrobe_n(writeStrobe_n),
    .outputEnable_n(outputEnable_n), .resetPinLow(resetPinLow),
    .highVoltDetect(highVoltDetect), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .readyBusyFlag(readyBusyFlag), .progMode(progMode),
    .arrAddr(arrAddr), .arrWrData(arrWrData), .arrFlashWr(arrFlashWr),
    .arrEepromWr(arrEepromWr), .arrEraseFlash(arrEraseFlash),
    .arrEraseEeprom(arrEraseEeprom), .arrRdData(arrRdData),
    .arrEeRdData(arrEeRdData), .fuseStoreIn(fuseStore),
    .fuseLatched(), .fuseWrEn(), .fuseWrSel(), .fuseWrData(),
    .lockBits(lockBits));

  nv_array_model u_nv (
    .clk(clk), .arrAddr(arrAddr), .arrWrData(arrWrData),
    .arrFlashWr(arrFlashWr), .arrEepromWr(arrEepromWr),
    .arrEraseFlash(arrEraseFlash), .arrEraseEeprom(arrEraseEeprom),
    .arrRdData(arrRdData), .arrEeRdData(arrEeRdData));

  // ==================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic load(input logic [1:0] act, input logic [1:0] bs,
                      input logic [7:0] d);
    {actionCodeBit1, actionCodeBit0} <= act;
    {byteSelectSecond, byteSelectFirst} <= bs;
    dataIn <= d;
    tick(1);
    strobeClockPin <= 1'b1;
    tick(4);
    strobeClockPin <= 1'b0;
    tick(4);
  endtask

  task automatic wrPulse;
    writeStrobe_n <= 1'b0;
    tick(4);
    writeStrobe_n <= 1'b1;
    tick(4);
  endtask

  task automatic latchPage;
    pageLatchPulse <= 1'b1;
    tick(4);
    pageLatchPulse <= 1'b0;
    tick(4);
  endtask

  task automatic waitReady;
    for (int k = 0; k < 3000 && readyBusyFlag !== 1'b1; k++) tick(1);
    check("ready", 16'h1, 16'(readyBusyFlag));
  endtask

  task automatic enter(input logic glitch);
    resetPinLow <= 1'b1;
    repeat (6) load(2'h0, 2'h0, 8'h00);
    tick(4);
    highVoltDetect <= 1'b1;
    resetPinLow <= 1'b0;
    tick(1);
    pageLatchPulse <= glitch;
    tick(20);
    pageLatchPulse <= 1'b0;
    check("progMode", 16'(!glitch), 16'(progMode));
    highVoltDetect <= !glitch;
    tick(2000);
    $display("entry test done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end
    else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==================================================
  // Sequence
  initial begin
    tick(20);
    rst_n <= 1'b1;
    tick(3);
    enter(1'b1);
    enter(1'b0);
    foreach (rows[i]) begin
      load(2'h2, 2'h0, rows[i][31:24]);
      load(2'h0, 2'h0, rows[i][23:16]);
      {byteSelectSecond, byteSelectFirst} <= rows[i][1:0];
      outputEnable_n <= 1'b0;
      tick(6);
      check("dataOe", 16'h1, 16'(dataOe));
      check("dataOut", 16'(rows[i][15:8]), 16'(dataOut));
      outputEnable_n <= 1'b1;
      tick(6);
      check("dataOe", 16'h0, 16'(dataOe));
    end
    $display("row test done");
    load(2'h2, 2'h0, 8'h20);
    load(2'h1, 2'h0, 8'hfc);
    wrPulse();
    waitReady();
    check("lock", 16'h00fc, 16'(lockBits));
    load(2'h2, 2'h0, 8'h80);
    wrPulse();
    check("busy", 16'h0, 16'(readyBusyFlag));
    check("lock", 16'h00fc, 16'(lockBits));
    check("eeErase", 16'h1, 16'(arrEraseEeprom));
    wrPulse();
    waitReady();
    check("lock", 16'h00ff, 16'(lockBits));
    check("flash", 16'hffff, u_nv.flashMem[5]);
    check("eeprom", 16'h00ff, 16'(u_nv.eeMem[7]));
    $display("erase test done");
    load(2'h2, 2'h0, 8'h10);
    for (int w = 1; w < 3; w++) begin
      load(2'h0, 2'h0, 8'h40 + 8'(w));
      load(2'h1, 2'h0, 8'h30 + 8'(w));
      load(2'h1, 2'h1, 8'hc0 + 8'(w));
      latchPage();
    end
    load(2'h0, 2'h1, 8'h00);
    wrPulse();
    check("busy", 16'h0, 16'(readyBusyFlag));
    waitReady();
    check("word", 16'hc131, u_nv.flashMem[13'h041]);
    check("word", 16'hc232, u_nv.flashMem[13'h042]);
    load(2'h2, 2'h0, 8'h00);
    wrPulse();
    check("idle", 16'h1, 16'(readyBusyFlag));
    $display("page test done");
    load(2'h2, 2'h0, 8'h11);
    load(2'h0, 2'h0, 8'h07);
    load(2'h1, 2'h0, 8'h3c);
    latchPage();
    wrPulse();
    waitReady();
    check("eeword", 16'h003c, 16'(u_nv.eeMem[7]));
    fuseStore[11] <= 1'b0;
    load(2'h2, 2'h0, 8'h80);
    wrPulse();
    check("eeErase", 16'h0, 16'(arrEraseEeprom));
    waitReady();
    check("eeprom", 16'h003c, 16'(u_nv.eeMem[7]));
    $display("keep test done");
    print_verdict();
  end

  initial begin
    tick(20000);
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
